// ---- rtl/btc_pkg.sv ----
// Shared constants, opcodes, states and the state record of the execution unit.
package btc_pkg;

	localparam int IO_AW = 6;
	localparam int DISP_W = 6;

	localparam logic [2:0] FLG_C = 3'h0;
	localparam logic [2:0] FLG_Z = 3'h1;
	localparam logic [2:0] FLG_N = 3'h2;
	localparam logic [2:0] FLG_V = 3'h3;
	localparam logic [2:0] FLG_S = 3'h4;
	localparam logic [2:0] FLG_H = 3'h5;
	localparam logic [2:0] FLG_T = 3'h6;
	localparam logic [2:0] FLG_I = 3'h7;

	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [15:0] PTR_STEP = 16'h0001;

	localparam logic [4:0] REG_X_LO = 5'h1a;
	localparam logic [4:0] REG_Y_LO = 5'h1c;
	localparam logic [4:0] REG_Z_LO = 5'h1e;
	localparam logic [4:0] REG_R0 = 5'h00;
	localparam logic [4:0] REG_R1 = 5'h01;
	localparam logic [4:0] PAIR_EVEN = 5'h1e;
	localparam logic [4:0] PAIR_ODD = 5'h01;

	localparam logic [1:0] PTR_X = 2'h0;
	localparam logic [1:0] PTR_Y = 2'h1;
	localparam logic [1:0] PTR_Z = 2'h2;

	localparam logic [1:0] MODE_PLAIN = 2'h0;
	localparam logic [1:0] MODE_POST = 2'h1;
	localparam logic [1:0] MODE_PRE = 2'h2;
	localparam logic [1:0] MODE_DISP = 2'h3;

	typedef enum logic [4:0] {
		OP_IDLE = 5'h00,
		OP_SET_IO = 5'h01,
		OP_CLR_IO = 5'h02,
		OP_ROT_LEFT = 5'h03,
		OP_ROT_RIGHT = 5'h04,
		OP_SHIFT_LEFT = 5'h05,
		OP_SHIFT_RIGHT = 5'h06,
		OP_ARITH_RIGHT = 5'h07,
		OP_BIT_TO_FLAG = 5'h08,
		OP_FLAG_TO_BIT = 5'h09,
		OP_FLAG_SET = 5'h0a,
		OP_FLAG_CLR = 5'h0b,
		OP_GIE = 5'h0c,
		OP_GID = 5'h0d,
		OP_COPY = 5'h0e,
		OP_PAIR_COPY = 5'h0f,
		OP_CONST = 5'h10,
		OP_PLOAD = 5'h11,
		OP_PSTORE = 5'h12,
		OP_DLOAD = 5'h13,
		OP_DSTORE = 5'h14,
		OP_CODE_RD = 5'h15,
		OP_CODE_WR = 5'h16,
		OP_IN = 5'h17,
		OP_OUT = 5'h18,
		OP_PUSH = 5'h19,
		OP_POP = 5'h1a,
		OP_SLEEP = 5'h1b,
		OP_WDOG = 5'h1c,
		OP_BREAK = 5'h1d
	} btc_op_t;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_DM = 3'h1,
		S_PM1 = 3'h2,
		S_PM2 = 3'h3,
		S_CWR = 3'h4,
		S_IOWR = 3'h5
	} btc_state_t;

	typedef struct packed {
		btc_state_t state;
		logic [31:0][7:0] rf;
		logic [7:0] status;
		logic [15:0] sp;
		logic [4:0] dst;
		logic [15:0] dm_addr;
		logic [7:0] dm_wdata;
		logic dm_we;
		logic dm_re;
		logic [15:0] pm_addr;
		logic [15:0] pm_wdata;
		logic pm_re;
		logic pm_we;
		logic [IO_AW-1:0] io_addr;
		logic [7:0] io_wdata;
		logic sleep;
		logic wdog;
		logic brk;
	} btc_regs_t;

endpackage : btc_pkg

// ---- rtl/btc_core.sv ----
// Execution unit for bit, data-transfer and control operations of an 8-bit core.
// Summary of operation
// - I/O bit set or clear touches one bit, keeps flags, takes two cycles.
// - Rotates pass carry through; logical shifts fill zero; one cycle, Z C N V.
// - Arithmetic right shift keeps bit seven; one cycle, updates Z C N V.
// - Bit store copies register bit to T; bit load copies T back.
// - Each flag set or clear changes only that status bit in one cycle.
// - Interrupt enable sets and disable clears the global flag in one cycle.
// - Register copy, pair copy and constant load take one cycle, keep flags.
// - Pointer loads read at pointer; post-increment bumps after; two cycles.
// - Pre-decrement load lowers the pointer first, then reads there; two cycles.
// - Offset load reads at Y or Z plus q, pointer unchanged, two cycles.
// - Direct load reads at the constant address in two cycles.
// - Pointer stores write at pointer with post-increment or pre-decrement; two cycles.
// - Offset store writes at Y or Z plus q, pointer unchanged, two cycles.
// - Direct store writes at the constant address in two cycles.
// - Code memory read loads byte at Z into chosen register; three cycles.
// - Code memory write sends R1:R0 to Z and waits for completion.
// - I/O input and output copy one location in one cycle.
// - Push and pop move a register to or from the stack in two cycles.
// - Break acts only with debug enabled; idle, sleep, restart take one cycle.
`timescale 1ns/100ps
module btc_core
	import btc_pkg::*;
#(
	parameter logic [15:0] SP_RESET = 16'hffff
) (
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic op_valid_i,
	input wire btc_op_t op_i,
	input wire logic [4:0] rd_i,
	input wire logic [4:0] rr_i,
	input wire logic [2:0] bit_i,
	input wire logic [15:0] imm_i,
	input wire logic [1:0] ptr_sel_i,
	input wire logic [1:0] ptr_mode_i,
	input wire logic debug_en_i,
	output logic ready_o,
	output logic [7:0] status_o,
	output logic [15:0] dmem_addr_o,
	output logic [7:0] dmem_wdata_o,
	output logic dmem_we_o,
	output logic dmem_re_o,
	input wire logic [7:0] dmem_rdata_i,
	output logic [IO_AW-1:0] io_addr_o,
	output logic [7:0] io_wdata_o,
	output logic io_we_o,
	output logic io_re_o,
	input wire logic [7:0] io_rdata_i,
	output logic [15:0] pmem_addr_o,
	output logic [15:0] pmem_wdata_o,
	output logic pmem_re_o,
	output logic pmem_we_o,
	input wire logic [7:0] pmem_rdata_i,
	input wire logic pmem_done_i,
	output logic sleep_o,
	output logic wdog_restart_o,
	output logic break_o
);

	if (SP_RESET == 16'h0000) begin : g_bad_sp
		$error("Stack pointer reset value must not be zero.");
	end

	btc_regs_t q;
	btc_regs_t d;
	logic take;
	logic [4:0] ptr_lo;
	logic [4:0] ptr_hi;
	logic [15:0] ptr_val;
	logic [15:0] ptr_inc;
	logic [15:0] ptr_dec;
	logic [15:0] ptr_ea;
	logic [15:0] ptr_upd;
	logic [15:0] z_val;
	logic [15:0] z_inc;
	logic [15:0] sp_inc;
	logic [15:0] dm_ea;
	logic [7:0] rd_v;
	logic [7:0] rr_v;
	logic [7:0] sh_res;
	logic sh_c;
	logic is_load;
	logic is_ptr_op;

	assign take = op_valid_i && (q.state == S_IDLE);
	assign rd_v = q.rf[rd_i];
	assign rr_v = q.rf[rr_i];
	assign ptr_lo = (ptr_sel_i == PTR_Y) ? REG_Y_LO : (ptr_sel_i == PTR_Z) ? REG_Z_LO : REG_X_LO;
	assign ptr_hi = ptr_lo | PAIR_ODD;
	assign ptr_val = {q.rf[ptr_hi], q.rf[ptr_lo]};
	assign ptr_inc = ptr_val + PTR_STEP;
	assign ptr_dec = ptr_val - PTR_STEP;
	assign z_val = {q.rf[REG_Z_LO | PAIR_ODD], q.rf[REG_Z_LO]};
	assign z_inc = z_val + PTR_STEP;
	assign sp_inc = q.sp + PTR_STEP;
	// Pre-decrement addresses the lowered pointer; offsets apply to Y and Z only.
	assign ptr_ea = (ptr_mode_i == MODE_PRE) ? ptr_dec :
		(ptr_mode_i == MODE_DISP && ptr_sel_i != PTR_X) ?
		ptr_val + {{(16 - DISP_W){1'b0}}, imm_i[DISP_W-1:0]} : ptr_val;
	assign ptr_upd = (ptr_mode_i == MODE_POST) ? ptr_inc :
		(ptr_mode_i == MODE_PRE) ? ptr_dec : ptr_val;
	assign dm_ea = (op_i == OP_DLOAD || op_i == OP_DSTORE) ? imm_i :
		(op_i == OP_PUSH) ? q.sp : (op_i == OP_POP) ? sp_inc : ptr_ea;
	assign is_load = (op_i == OP_PLOAD) || (op_i == OP_DLOAD) || (op_i == OP_POP);
	assign is_ptr_op = (op_i == OP_PLOAD) || (op_i == OP_PSTORE);
	assign sh_res = (op_i == OP_ROT_LEFT) ? {rd_v[6:0], q.status[FLG_C]} :
		(op_i == OP_ROT_RIGHT) ? {q.status[FLG_C], rd_v[7:1]} :
		(op_i == OP_SHIFT_LEFT) ? {rd_v[6:0], 1'b0} :
		(op_i == OP_SHIFT_RIGHT) ? {1'b0, rd_v[7:1]} : {rd_v[7], rd_v[7:1]};
	assign sh_c = (op_i == OP_ROT_LEFT || op_i == OP_SHIFT_LEFT) ? rd_v[7] : rd_v[0];

	always_comb begin
		d = q;
		d.sleep = 1'b0;
		d.wdog = 1'b0;
		d.brk = 1'b0;
		unique case (q.state)
			S_IDLE: begin
				if (op_valid_i) begin
					unique case (op_i)
						OP_SET_IO, OP_CLR_IO: begin
							d.io_addr = imm_i[IO_AW-1:0];
							d.io_wdata = io_rdata_i;
							d.io_wdata[bit_i] = (op_i == OP_SET_IO);
							d.state = S_IOWR;
						end
						OP_ROT_LEFT, OP_ROT_RIGHT, OP_SHIFT_LEFT, OP_SHIFT_RIGHT,
						OP_ARITH_RIGHT: begin
							d.rf[rd_i] = sh_res;
							d.status[FLG_C] = sh_c;
							d.status[FLG_Z] = (sh_res == 8'h00);
							d.status[FLG_N] = sh_res[7];
							d.status[FLG_V] = sh_res[7] ^ sh_c;
						end
						OP_BIT_TO_FLAG: d.status[FLG_T] = rd_v[bit_i];
						OP_FLAG_TO_BIT: d.rf[rd_i][bit_i] = q.status[FLG_T];
						OP_FLAG_SET: d.status[bit_i] = 1'b1;
						OP_FLAG_CLR: d.status[bit_i] = 1'b0;
						OP_GIE: d.status[FLG_I] = 1'b1;
						OP_GID: d.status[FLG_I] = 1'b0;
						OP_COPY: d.rf[rd_i] = rr_v;
						OP_PAIR_COPY: begin
							d.rf[rd_i & PAIR_EVEN] = q.rf[rr_i & PAIR_EVEN];
							d.rf[rd_i | PAIR_ODD] = q.rf[rr_i | PAIR_ODD];
						end
						OP_CONST: d.rf[rd_i] = imm_i[7:0];
						OP_PLOAD, OP_PSTORE, OP_DLOAD, OP_DSTORE, OP_PUSH, OP_POP: begin
							d.dm_addr = dm_ea;
							d.dm_wdata = rr_v;
							d.dm_re = is_load;
							d.dm_we = !is_load;
							d.dst = rd_i;
							d.state = S_DM;
							if (is_ptr_op) begin
								d.rf[ptr_lo] = ptr_upd[7:0];
								d.rf[ptr_hi] = ptr_upd[15:8];
							end
							if (op_i == OP_PUSH) begin
								d.sp = q.sp - PTR_STEP;
							end
							if (op_i == OP_POP) begin
								d.sp = sp_inc;
							end
						end
						OP_CODE_RD: begin
							d.pm_addr = z_val;
							d.pm_re = 1'b1;
							d.dst = rd_i;
							d.state = S_PM1;
							if (ptr_mode_i == MODE_POST) begin
								d.rf[REG_Z_LO] = z_inc[7:0];
								d.rf[REG_Z_LO | PAIR_ODD] = z_inc[15:8];
							end
						end
						OP_CODE_WR: begin
							d.pm_addr = z_val;
							d.pm_wdata = {q.rf[REG_R1], q.rf[REG_R0]};
							d.pm_we = 1'b1;
							d.state = S_CWR;
						end
						OP_IN: d.rf[rd_i] = io_rdata_i;
						OP_SLEEP: d.sleep = 1'b1;
						OP_WDOG: d.wdog = 1'b1;
						OP_BREAK: d.brk = debug_en_i;
						default: d.state = S_IDLE;
					endcase
				end
			end
			S_DM: begin
				if (q.dm_re) begin
					d.rf[q.dst] = dmem_rdata_i;
				end
				d.dm_re = 1'b0;
				d.dm_we = 1'b0;
				d.state = S_IDLE;
			end
			S_PM1: d.state = S_PM2;
			S_PM2: begin
				d.rf[q.dst] = pmem_rdata_i;
				d.pm_re = 1'b0;
				d.state = S_IDLE;
			end
			S_CWR: begin
				if (pmem_done_i) begin
					d.pm_we = 1'b0;
					d.state = S_IDLE;
				end
			end
			S_IOWR: d.state = S_IDLE;
			default: d.state = S_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			q <= '0;
			q.sp <= SP_RESET;
			q.status <= STATUS_RESET;
		end else begin
			q <= d;
		end
	end

	assign ready_o = (q.state == S_IDLE);
	assign status_o = q.status;
	assign dmem_addr_o = q.dm_addr;
	assign dmem_wdata_o = q.dm_wdata;
	assign dmem_we_o = q.dm_we;
	assign dmem_re_o = q.dm_re;
	assign pmem_addr_o = q.pm_addr;
	assign pmem_wdata_o = q.pm_wdata;
	assign pmem_re_o = q.pm_re;
	assign pmem_we_o = q.pm_we;
	assign sleep_o = q.sleep;
	assign wdog_restart_o = q.wdog;
	assign break_o = q.brk;
	// The I/O port is combinational in idle so input and output finish in one cycle.
	assign io_addr_o = (q.state == S_IOWR) ? q.io_addr : imm_i[IO_AW-1:0];
	assign io_wdata_o = (q.state == S_IOWR) ? q.io_wdata : rr_v;
	assign io_we_o = (q.state == S_IOWR) || (take && op_i == OP_OUT);
	assign io_re_o = take && (op_i == OP_IN || op_i == OP_SET_IO || op_i == OP_CLR_IO);

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);

	a_io_bit_write: assert property (take && (op_i == OP_SET_IO || op_i == OP_CLR_IO) |=>
		!ready_o && io_we_o && io_wdata_o[$past(bit_i)] == ($past(op_i) == OP_SET_IO)
		##1 ready_o && status_o == $past(status_o, 2))
		else $error("I/O bit operation wrong.");
	a_rotate_carry: assert property (take && op_i == OP_ROT_LEFT |=>
		status_o[FLG_C] == $past(rd_v[7]) &&
		q.rf[$past(rd_i)] == {$past(rd_v[6:0]), $past(status_o[FLG_C])})
		else $error("Rotate left through carry wrong.");
	a_asr_msb: assert property (take && op_i == OP_ARITH_RIGHT |=>
		q.rf[$past(rd_i)] == {$past(rd_v[7]), $past(rd_v[7:1])} && status_o[FLG_C] == $past(rd_v[0]))
		else $error("Arithmetic shift wrong.");
	a_bit_to_t: assert property (take && op_i == OP_BIT_TO_FLAG |=>
		status_o[FLG_T] == $past(rd_v[bit_i]) && ready_o)
		else $error("Bit store to T wrong.");
	a_flag_one_bit: assert property (take && op_i == OP_FLAG_SET |=>
		status_o == ($past(status_o) | (8'h01 << $past(bit_i))) && ready_o)
		else $error("Flag set touched other bits.");
	a_irq_enable: assert property (take && (op_i == OP_GIE || op_i == OP_GID) |=>
		status_o[FLG_I] == ($past(op_i) == OP_GIE))
		else $error("Global interrupt flag wrong.");
	a_pair_copy: assert property (take && op_i == OP_PAIR_COPY |=>
		q.rf[$past(rd_i) | PAIR_ODD] == $past(q.rf[rr_i | PAIR_ODD]) && status_o == $past(status_o))
		else $error("Pair copy wrong.");
	a_post_inc: assert property (take && op_i == OP_PLOAD && ptr_mode_i == MODE_POST &&
		(rd_i | PAIR_ODD) != ptr_hi |=> dmem_addr_o == $past(ptr_val) &&
		{q.rf[$past(ptr_hi)], q.rf[$past(ptr_lo)]} == $past(ptr_inc))
		else $error("Post-increment load wrong.");
	a_disp_load_addr: assert property (take && op_i == OP_PLOAD && ptr_mode_i == MODE_DISP &&
		ptr_sel_i == PTR_Y |=> dmem_addr_o == $past(ptr_val) + 16'($past(imm_i[DISP_W-1:0])))
		else $error("Offset load address wrong.");
	a_direct_addr: assert property (take && op_i == OP_DLOAD |=>
		dmem_addr_o == $past(imm_i) && dmem_re_o)
		else $error("Direct load address wrong.");
	a_store_two_cyc: assert property (take && (op_i == OP_PSTORE || op_i == OP_DSTORE) |=>
		!ready_o && dmem_we_o && dmem_wdata_o == $past(rr_v) ##1 ready_o && !dmem_we_o)
		else $error("Store did not finish in two cycles.");
	a_code_wr_hold: assert property (pmem_we_o && !pmem_done_i |=>
		pmem_we_o && !ready_o)
		else $error("Code memory write ended early.");
	a_io_out_one: assert property (take && op_i == OP_OUT |->
		io_we_o && io_wdata_o == rr_v ##1 ready_o)
		else $error("I/O output wrong.");
	a_stack_push: assert property (take && op_i == OP_PUSH |=>
		dmem_addr_o == $past(q.sp) && q.sp == $past(q.sp) - PTR_STEP && dmem_we_o)
		else $error("Push wrong.");
	a_break_gate: assert property (take && op_i == OP_BREAK && !debug_en_i |=>
		!break_o)
		else $error("Break acted without debug.");
	a_load_two_cyc: assert property (take && is_load |=>
		!ready_o && dmem_re_o ##1 ready_o && q.rf[$past(rd_i, 2)] == $past(dmem_rdata_i))
		else $error("Load did not finish in two cycles.");
	a_predec_addr: assert property (take && op_i == OP_PLOAD && ptr_mode_i == MODE_PRE |=>
		dmem_addr_o == $past(ptr_val) - PTR_STEP)
		else $error("Pre-decrement address wrong.");
	a_disp_ptr_keep: assert property (take && op_i == OP_PSTORE && ptr_mode_i == MODE_DISP |=>
		{q.rf[$past(ptr_hi)], q.rf[$past(ptr_lo)]} == $past(ptr_val) && dmem_we_o)
		else $error("Offset store moved the pointer.");
	a_code_rd_three: assert property (take && op_i == OP_CODE_RD |=>
		!ready_o [*2] ##1 ready_o && q.rf[$past(rd_i, 3)] == $past(pmem_rdata_i))
		else $error("Code memory read not three cycles.");
	a_shift_flags: assert property (take && op_i == OP_SHIFT_RIGHT |=>
		!status_o[FLG_N] && status_o[FLG_Z] == (q.rf[$past(rd_i)] == 8'h00) &&
		status_o[FLG_V] == status_o[FLG_C])
		else $error("Shift flags wrong.");

	c_io_bit: cover property (take && op_i == OP_SET_IO ##2 ready_o);
	c_pop: cover property (take && op_i == OP_POP ##2 take && op_i == OP_PUSH);
	c_code_rd_post: cover property (take && op_i == OP_CODE_RD && ptr_mode_i == MODE_POST ##3 ready_o);
	c_code_wr_done: cover property (take && op_i == OP_CODE_WR ##[1:20] pmem_done_i);

endmodule : btc_core

// ---- dv/btc_mem_model.sv ----
// Data memory, I/O space and code memory seen by the execution unit.
`timescale 1ns/100ps
module btc_mem_model
	import btc_pkg::*;
(
	input wire logic clk_sys_i,
	input wire logic [15:0] dmem_addr_i,
	input wire logic [7:0] dmem_wdata_i,
	input wire logic dmem_we_i,
	input wire logic dmem_re_i,
	output logic [7:0] dmem_rdata_o,
	input wire logic [IO_AW-1:0] io_addr_i,
	input wire logic [7:0] io_wdata_i,
	input wire logic io_we_i,
	input wire logic io_re_i,
	output logic [7:0] io_rdata_o,
	input wire logic [15:0] pmem_addr_i,
	input wire logic [15:0] pmem_wdata_i,
	input wire logic pmem_we_i,
	input wire logic pmem_re_i,
	output logic [7:0] pmem_rdata_o,
	output logic pmem_done_o,
	input wire logic [3:0] done_lat_i,
	output logic [15:0] pm_word_o,
	output logic [15:0] pm_waddr_o
);
	logic [7:0] dmem [256];
	logic [7:0] io [64];
	logic [3:0] cnt;
	initial begin
		for (int i = 0; i < 256; i++) begin
			dmem[i] = 8'(i) ^ 8'ha5;
		end
		for (int i = 0; i < 64; i++) begin
			io[i] = 8'(i) ^ 8'h17;
		end
		cnt = 4'h0;
	end
	// Released read lines show the inverse so a late sample cannot pass by luck.
	assign dmem_rdata_o = dmem_re_i ? dmem[dmem_addr_i[7:0]] : ~dmem[dmem_addr_i[7:0]];
	assign io_rdata_o = io_re_i ? io[io_addr_i] : ~io[io_addr_i];
	assign pmem_rdata_o = (pmem_addr_i[7:0] ^ 8'h69) ^ {8{~pmem_re_i}};
	assign pmem_done_o = pmem_we_i && (cnt == done_lat_i);
	always @(posedge clk_sys_i) begin
		if (dmem_we_i) begin
			dmem[dmem_addr_i[7:0]] <= dmem_wdata_i;
		end
		if (io_we_i) begin
			io[io_addr_i] <= io_wdata_i;
		end
		cnt <= pmem_we_i ? cnt + 4'h1 : 4'h0;
		if (pmem_done_o) begin
			pm_word_o <= pmem_wdata_i;
			pm_waddr_o <= pmem_addr_i;
		end
	end
endmodule : btc_mem_model

// ---- dv/cpu_bit_transfer_control_ops_tb.sv ----
// Self-checking bench for the bit, transfer and control execution unit.
`timescale 1ns/100ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
$display("unexpected at %0t: got %h expected %h", $time, (a), (e)); end end
module cpu_bit_transfer_control_ops_tb;
	import btc_pkg::*;
	typedef struct {btc_op_t o; int d, r, b, k, p, m, n; logic [7:0] f, v; int c;} btc_row_t;
	logic clk_sys_i, rst_i, op_valid_i, debug_en_i, ready_o;
	btc_op_t op_i;
	logic [4:0] rd_i, rr_i;
	logic [2:0] bit_i;
	logic [15:0] imm_i, dmem_addr_o, pmem_addr_o, pmem_wdata_o, pm_word, pm_waddr;
	logic [1:0] ptr_sel_i, ptr_mode_i;
	logic [7:0] status_o, dmem_wdata_o, dmem_rdata_i, io_wdata_o, io_rdata_i, pmem_rdata_i;
	logic dmem_we_o, dmem_re_o, io_we_o, io_re_o, pmem_re_o, pmem_we_o, pmem_done_i;
	logic sleep_o, wdog_restart_o, break_o;
	logic [IO_AW-1:0] io_addr_o;
	logic [3:0] done_lat;
	logic [7:0] seen, s;
	int failures, n_compared, busy, n_slp, n_wdog, n_brk;
	btc_row_t rows[42] = '{
		'{OP_CONST, 16, 0, 0, 8'h81, 0, 0, 0, 8'h00, 8'h81, 16},
		'{OP_SHIFT_LEFT, 16, 0, 0, 0, 0, 0, 0, 8'h09, 8'h02, 16},
		'{OP_ROT_RIGHT, 16, 0, 0, 0, 0, 0, 0, 8'h0c, 8'h81, 16},
		'{OP_ROT_LEFT, 16, 0, 0, 0, 0, 0, 0, 8'h09, 8'h02, 16},
		'{OP_SHIFT_RIGHT, 16, 0, 0, 0, 0, 0, 0, 8'h00, 8'h01, 16},
		'{OP_SHIFT_RIGHT, 16, 0, 0, 0, 0, 0, 0, 8'h0b, 8'h00, 16},
		'{OP_CONST, 17, 0, 0, 8'h80, 0, 0, 0, 8'h0b, 8'h80, 17},
		'{OP_ARITH_RIGHT, 17, 0, 0, 0, 0, 0, 0, 8'h0c, 8'hc0, 17},
		'{OP_BIT_TO_FLAG, 17, 0, 6, 0, 0, 0, 0, 8'h4c, 8'hc0, 17},
		'{OP_FLAG_TO_BIT, 16, 0, 3, 0, 0, 0, 0, 8'h4c, 8'h08, 16},
		'{OP_GIE, 0, 0, 0, 0, 0, 0, 0, 8'hcc, 8'h08, 16},
		'{OP_GID, 0, 0, 0, 0, 0, 0, 0, 8'h4c, 8'h08, 16},
		'{OP_COPY, 18, 17, 0, 0, 0, 0, 0, 8'h4c, 8'hc0, 18},
		'{OP_PAIR_COPY, 2, 16, 0, 0, 0, 0, 0, 8'h4c, 8'hc0, 3},
		'{OP_CONST, 26, 0, 0, 8'h11, 0, 0, 0, 8'h4c, 8'h11, 26},
		'{OP_PLOAD, 20, 0, 0, 0, 0, 2, 1, 8'h4c, 8'hb5, 20},
		'{OP_PLOAD, 21, 0, 0, 0, 0, 1, 1, 8'h4c, 8'h11, 26},
		'{OP_PLOAD, 22, 0, 0, 0, 0, 0, 1, 8'h4c, 8'hb4, 22},
		'{OP_CONST, 28, 0, 0, 8'h20, 0, 0, 0, 8'h4c, 8'h20, 28},
		'{OP_PLOAD, 23, 0, 0, 5, 1, 3, 1, 8'h4c, 8'h80, 23},
		'{OP_IDLE, 0, 0, 0, 0, 0, 0, 0, 8'h4c, 8'h20, 28},
		'{OP_DLOAD, 24, 0, 0, 8'h33, 0, 0, 1, 8'h4c, 8'h96, 24},
		'{OP_DSTORE, 0, 17, 0, 8'h40, 0, 0, 1, 8'h4c, 8'hc0, 17},
		'{OP_DLOAD, 24, 0, 0, 8'h40, 0, 0, 1, 8'h4c, 8'hc0, 24},
		'{OP_CONST, 30, 0, 0, 8'h50, 0, 0, 0, 8'h4c, 8'h50, 30},
		'{OP_PSTORE, 0, 16, 0, 0, 2, 1, 1, 8'h4c, 8'h51, 30},
		'{OP_PSTORE, 0, 18, 0, 0, 2, 2, 1, 8'h4c, 8'h50, 30},
		'{OP_DLOAD, 25, 0, 0, 8'h50, 0, 0, 1, 8'h4c, 8'hc0, 25},
		'{OP_PSTORE, 0, 16, 0, 3, 1, 3, 1, 8'h4c, 8'h20, 28},
		'{OP_DLOAD, 25, 0, 0, 8'h23, 0, 0, 1, 8'h4c, 8'h08, 25},
		'{OP_PUSH, 0, 16, 0, 0, 0, 0, 1, 8'h4c, 8'h08, 16},
		'{OP_PUSH, 0, 17, 0, 0, 0, 0, 1, 8'h4c, 8'hc0, 17},
		'{OP_POP, 19, 0, 0, 0, 0, 0, 1, 8'h4c, 8'hc0, 19},
		'{OP_POP, 19, 0, 0, 0, 0, 0, 1, 8'h4c, 8'h08, 19},
		'{OP_CODE_RD, 0, 0, 0, 0, 2, 0, 2, 8'h4c, 8'h39, 0},
		'{OP_CODE_RD, 5, 0, 0, 0, 2, 1, 2, 8'h4c, 8'h39, 5},
		'{OP_IDLE, 0, 0, 0, 0, 0, 0, 0, 8'h4c, 8'h51, 30},
		'{OP_IN, 6, 0, 0, 5, 0, 0, 0, 8'h4c, 8'h12, 6},
		'{OP_SET_IO, 0, 0, 0, 5, 0, 0, 1, 8'h4c, 8'h12, 6},
		'{OP_IN, 7, 0, 0, 5, 0, 0, 0, 8'h4c, 8'h13, 7},
		'{OP_CLR_IO, 0, 0, 4, 5, 0, 0, 1, 8'h4c, 8'h13, 7},
		'{OP_IN, 7, 0, 0, 5, 0, 0, 0, 8'h4c, 8'h03, 7}
	};
	btc_core u_btc_core (
		.clk_sys_i(clk_sys_i),
		.rst_i(rst_i),
		.op_valid_i(op_valid_i),
		.op_i(op_i),
		.rd_i(rd_i),
		.rr_i(rr_i),
		.bit_i(bit_i),
		.imm_i(imm_i),
		.ptr_sel_i(ptr_sel_i),
		.ptr_mode_i(ptr_mode_i),
		.debug_en_i(debug_en_i),
		.ready_o(ready_o),
		.status_o(status_o),
		.dmem_addr_o(dmem_addr_o),
		.dmem_wdata_o(dmem_wdata_o),
		.dmem_we_o(dmem_we_o),
		.dmem_re_o(dmem_re_o),
		.dmem_rdata_i(dmem_rdata_i),
		.io_addr_o(io_addr_o),
		.io_wdata_o(io_wdata_o),
		.io_we_o(io_we_o),
		.io_re_o(io_re_o),
		.io_rdata_i(io_rdata_i),
		.pmem_addr_o(pmem_addr_o),
		.pmem_wdata_o(pmem_wdata_o),
		.pmem_re_o(pmem_re_o),
		.pmem_we_o(pmem_we_o),
		.pmem_rdata_i(pmem_rdata_i),
		.pmem_done_i(pmem_done_i),
		.sleep_o(sleep_o),
		.wdog_restart_o(wdog_restart_o),
		.break_o(break_o)
	);
	btc_mem_model u_btc_mem_model (.clk_sys_i(clk_sys_i), .dmem_addr_i(dmem_addr_o),
		.dmem_wdata_i(dmem_wdata_o), .dmem_we_i(dmem_we_o), .dmem_re_i(dmem_re_o),
		.dmem_rdata_o(dmem_rdata_i), .io_addr_i(io_addr_o), .io_wdata_i(io_wdata_o),
		.io_we_i(io_we_o), .io_re_i(io_re_o), .io_rdata_o(io_rdata_i),
		.pmem_addr_i(pmem_addr_o), .pmem_wdata_i(pmem_wdata_o), .pmem_we_i(pmem_we_o),
		.pmem_re_i(pmem_re_o), .pmem_rdata_o(pmem_rdata_i), .pmem_done_o(pmem_done_i),
		.done_lat_i(done_lat), .pm_word_o(pm_word), .pm_waddr_o(pm_waddr));
	initial begin
		clk_sys_i = 1'b0;
		forever #20 clk_sys_i = ~clk_sys_i;
	end
	always @(posedge clk_sys_i) begin
		n_slp += int'(sleep_o === 1'b1);
		n_wdog += int'(wdog_restart_o === 1'b1);
		n_brk += int'(break_o === 1'b1);
	end
	task automatic conclude;
		if (failures == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : conclude
	// Offers one operation, notes the I/O write data seen while it is offered
	// and counts the cycles that ready stays low after the taking edge.
	task automatic issue(btc_op_t o, int d, int r, int b, int k, int p, int m);
		@(posedge clk_sys_i);
		op_valid_i <= 1'b1;
		op_i <= o;
		rd_i <= 5'(d);
		rr_i <= 5'(r);
		bit_i <= 3'(b);
		imm_i <= 16'(k);
		ptr_sel_i <= 2'(p);
		ptr_mode_i <= 2'(m);
		#1 seen = io_wdata_o;
		@(posedge clk_sys_i);
		op_valid_i <= 1'b0;
		busy = 0;
		#1;
		while (ready_o !== 1'b1) begin
			@(posedge clk_sys_i);
			#1 busy++;
			if (busy > 20) begin
				failures++;
				conclude();
			end
		end
	endtask : issue
	initial begin
		rst_i = 1'b1;
		op_valid_i = 1'b0;
		op_i = OP_IDLE;
		{rd_i, rr_i, bit_i, imm_i, ptr_sel_i, ptr_mode_i} = '0;
		debug_en_i = 1'b0;
		done_lat = 4'h0;
		repeat (6) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		foreach (rows[i]) begin
			issue(rows[i].o, rows[i].d, rows[i].r, rows[i].b, rows[i].k, rows[i].p, rows[i].m);
			`CHK(busy, rows[i].n)
			`CHK(status_o, rows[i].f)
			issue(OP_OUT, 0, rows[i].c, 0, 63, 0, 0);
			`CHK(seen, rows[i].v)
		end
		s = 8'h4c;
		for (int i = 0; i < 8; i++) begin
			issue(OP_FLAG_SET, 0, 0, i, 0, 0, 0);
			`CHK(status_o, s | (8'h01 << i))
			issue(OP_FLAG_CLR, 0, 0, i, 0, 0, 0);
			s = s & ~(8'h01 << i);
			`CHK(status_o, s)
			`CHK(busy, 0)
		end
		issue(OP_CONST, 1, 0, 0, 8'hab, 0, 0);
		for (int lat = 2; lat >= 0; lat -= 2) begin
			done_lat <= 4'(lat);
			issue(OP_CODE_WR, 0, 0, 0, 0, 0, 0);
			`CHK(busy, lat + 1)
			`CHK(pm_word, 16'hab39)
			`CHK(pm_waddr, 16'h0051)
		end
		issue(OP_SLEEP, 0, 0, 0, 0, 0, 0);
		`CHK(busy, 0)
		issue(OP_WDOG, 0, 0, 0, 0, 0, 0);
		issue(OP_BREAK, 0, 0, 0, 0, 0, 0);
		debug_en_i <= 1'b1;
		issue(OP_BREAK, 0, 0, 0, 0, 0, 0);
		repeat (2) @(posedge clk_sys_i);
		`CHK(n_slp, 1)
		`CHK(n_wdog, 1)
		`CHK(n_brk, 1)
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_sys_i);
		rst_i <= 1'b0;
		#1 `CHK(ready_o, 1'b1)
		`CHK(status_o, 8'h00)
		issue(OP_OUT, 0, 16, 0, 63, 0, 0);
		`CHK(seen, 8'h00)
		conclude();
	end
endmodule : cpu_bit_transfer_control_ops_tb
